/* File: hw/addon_fifo_defines.vh */
// Constants for the add-on FIFO port: offsets, status fields, modes, depth
`ifndef ADDON_FIFO_DEFINES_VH
`define ADDON_FIFO_DEFINES_VH

// Register byte offsets on the add-on bus
`define FIFO_PORT_OFS 7'h20
`define GEN_CTRL_STATUS_OFS 7'h3c

// Data width and depth of each direction's storage
`define FIFO_WIDTH 32
`define FIFO_DEPTH 8
`define FIFO_CNT_W 4
// Depth at the width of the occupancy count
`define FIFO_DEPTH_CNT 4'h8

// Threshold for the "four or more spaces" flag
`define FIFO_SPACE_THRESH 4'h4

// Status field positions, PCI to add-on direction
`define ST_P2A_FULL 0
`define ST_P2A_SPACE4 1
`define ST_P2A_EMPTY 2
// Status field positions, add-on to PCI direction
`define ST_A2P_FULL 3
`define ST_A2P_SPACE4 4
`define ST_A2P_EMPTY 5
`define ST_WIDTH 6

// Endian conversion modes set from the PCI side
`define ENDIAN_NONE 2'h0
`define ENDIAN_16 2'h1
`define ENDIAN_32 2'h2
`define ENDIAN_64 2'h3

`endif

/* File: hw/word_fifo.v */
// Flip-flop FIFO with valid/ready on both sides and an occupancy count
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
   parameter WIDTH = 32, // Word width
   parameter DEPTH = 8, // Number of words
   parameter AW = 3, // Index width
   parameter CW = 4 // Count width
) (
   input wire clk, // Add-on clock
   input wire reset, // Async reset, active high
   input wire in_valid, // Write request
   output wire in_ready, // Room for a word
   input wire [WIDTH-1:0] in_data, // Word to store
   output wire out_valid, // Word at head
   input wire out_ready, // Head taken
   output wire [WIDTH-1:0] out_data, // Head word
   output reg [CW-1:0] count // Words held
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
   reg [AW-1:0] wr_ptr; // Next slot to fill
   reg [AW-1:0] rd_ptr; // Head slot
   wire push; // Word enters
   wire pop; // Word leaves

   // Honest flags straight from the count
   assign in_ready = (count != DEPTH[CW-1:0]);
   assign out_valid = (count != {CW{1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];

   // Pointers and count
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {CW{1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end

   // Storage write, no reset needed on data
   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // word_fifo
`default_nettype wire

/* File: hw/addon_fifo_port.v */
// Add-on side FIFO data port with flag pins, status register and PCI-side hooks
//
// What this block does
// - FIFO data port at offset 20h, 32 bits
// - Reads and writes use separate storage
// - PCI-side setting governs byte order on fill and drain
// - Empty, four-space and full flags shown in both status registers
// - Pin shows read-side data available
// - Pin shows write-side space available
// - 64-bit conversion paces both flag pins by DWORD pairs
// - Dedicated active-low FIFO read/write strobes
// - Empty, four-space and full flags reported
`timescale 1ns/100ps
`default_nettype none
`include "addon_fifo_defines.vh"
module addon_fifo_port (
   input wire clk, // Add-on bus clock, 100 MHz
   input wire reset, // Async reset, active high
   input wire addon_select_n, // Register chip select, active low
   input wire addon_rd_n, // Register read strobe, active low
   input wire addon_wr_n, // Register write strobe, active low
   input wire [6:2] addon_addr, // DWORD register address
   input wire [31:0] addon_data_in, // Data bus, sensed level
   output reg [31:0] addon_data_out, // Data bus, driven level
   output reg addon_data_oe, // Data bus driven when high
   input wire fifo_read_strobe_n, // Dedicated FIFO read, active low
   input wire fifo_write_strobe_n, // Dedicated FIFO write, active low
   output wire fifo_data_available_pin, // Read side holds data
   output wire fifo_space_available_pin, // Write side has room
   input wire [1:0] pci_endian_mode, // Conversion mode from PCI control
   input wire pci_wr_valid, // PCI side offers a word
   input wire [31:0] pci_wr_data, // Word from PCI side
   output wire pci_wr_ready, // PCI to add-on FIFO has room
   output wire pci_rd_valid, // Add-on to PCI word ready
   output wire [31:0] pci_rd_data, // Word toward PCI side
   input wire pci_rd_ready, // PCI side takes the word
   output reg [`ST_WIDTH-1:0] pci_fifo_status // Flags for PCI master status
);
   wire [`FIFO_WIDTH-1:0] p2a_head; // Head of PCI to add-on FIFO
   wire p2a_valid; // PCI to add-on FIFO not empty
   wire p2a_pop; // Word leaves toward add-on
   wire [`FIFO_CNT_W-1:0] p2a_count; // Words held, read side
   wire a2p_ready; // Add-on to PCI FIFO has room
   wire a2p_push; // Word enters from add-on
   wire [`FIFO_CNT_W-1:0] a2p_count; // Words held, write side
   wire reg_sel; // Register cycle selected
   wire reg_rd; // Register read this cycle
   wire reg_wr; // Register write this cycle
   wire hit_fifo; // Address hits FIFO port
   wire hit_status; // Address hits general status
   wire fifo_rd_req; // Any add-on read of the FIFO
   wire fifo_wr_req; // Any add-on write of the FIFO
   wire mode64; // 64-bit conversion active
   wire [`ST_WIDTH-1:0] status_now; // Live flag set
   wire [`FIFO_CNT_W-1:0] a2p_free; // Free slots, write side
   reg rd_phase; // Second half of a read pair pending
   reg wr_phase; // Second half of a write pair pending

   // Byte reversal inside each 16-bit half
   function [31:0] swap16;
      input [31:0] d; // Word to convert
      begin
         swap16 = {d[23:16], d[31:24], d[7:0], d[15:8]};
      end
   endfunction

   // Byte reversal across the DWORD
   function [31:0] swap32;
      input [31:0] d; // Word to convert
      begin
         swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
      end
   endfunction

   // Conversion picked by the PCI-side mode
   function [31:0] convert;
      input [31:0] d; // Word to convert
      input [1:0] mode; // Conversion mode
      begin
         case (mode)
            `ENDIAN_16: convert = swap16(d); // Swap within halves
            `ENDIAN_32: convert = swap32(d); // Full DWORD swap
            `ENDIAN_64: convert = swap32(d); // Per DWORD, moved in pairs
            default: convert = d; // No conversion
         endcase
      end
   endfunction

   // The three flags of one direction, empty / four-space / full
   function [2:0] dir_flags;
      input [`FIFO_CNT_W-1:0] cnt; // Words held
      reg [`FIFO_CNT_W-1:0] free; // Free slots
      begin
         free = `FIFO_DEPTH_CNT - cnt;
         dir_flags = {cnt == {`FIFO_CNT_W{1'b0}}, free >= `FIFO_SPACE_THRESH, free == {`FIFO_CNT_W{1'b0}}};
      end
   endfunction

   // Register bus decode; bus is synchronous to clk
   assign reg_sel = ~addon_select_n;
   assign reg_rd = reg_sel & ~addon_rd_n;
   assign reg_wr = reg_sel & ~addon_wr_n;
   assign hit_fifo = ({addon_addr, 2'b00} == `FIFO_PORT_OFS);
   assign hit_status = ({addon_addr, 2'b00} == `GEN_CTRL_STATUS_OFS);

   // Register port and dedicated strobes both reach the FIFO
   assign fifo_rd_req = (reg_rd & hit_fifo) | ~fifo_read_strobe_n;
   assign fifo_wr_req = (reg_wr & hit_fifo) | ~fifo_write_strobe_n;

   // Reads drain one FIFO, writes fill the other
   assign p2a_pop = fifo_rd_req & p2a_valid;
   assign a2p_push = fifo_wr_req & a2p_ready;

   assign mode64 = (pci_endian_mode == `ENDIAN_64);

   // PCI to add-on direction: add-on reads drain it
   word_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH),
      .AW(3),
      .CW(`FIFO_CNT_W)
   ) u_p2a (
      .clk(clk),
      .reset(reset),
      .in_valid(pci_wr_valid),
      .in_ready(pci_wr_ready),
      .in_data(pci_wr_data),
      .out_valid(p2a_valid),
      .out_ready(p2a_pop),
      .out_data(p2a_head),
      .count(p2a_count)
   );

   // Add-on to PCI direction: add-on writes fill it, converted on entry
   word_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH),
      .AW(3),
      .CW(`FIFO_CNT_W)
   ) u_a2p (
      .clk(clk),
      .reset(reset),
      .in_valid(fifo_wr_req),
      .in_ready(a2p_ready),
      .in_data(convert(addon_data_in, pci_endian_mode)),
      .out_valid(pci_rd_valid),
      .out_ready(pci_rd_ready),
      .out_data(pci_rd_data),
      .count(a2p_count)
   );

   assign a2p_free = `FIFO_DEPTH_CNT - a2p_count;

   // Pair phase trackers for 64-bit conversion
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_phase <= 1'b0;
         wr_phase <= 1'b0;
      end else begin
         // Outside 64-bit mode every word stands alone
         if (!mode64) begin
            rd_phase <= 1'b0;
         end else if (p2a_pop) begin
            rd_phase <= ~rd_phase;
         end
         if (!mode64) begin
            wr_phase <= 1'b0;
         end else if (a2p_push) begin
            wr_phase <= ~wr_phase;
         end
      end
   end

   // Data available: a whole pair in 64-bit mode unless mid-pair
   assign fifo_data_available_pin = (mode64 & ~rd_phase) ?
      (p2a_count >= 4'h2) : p2a_valid;

   // Space available: room for a whole pair in 64-bit mode unless mid-pair
   assign fifo_space_available_pin = (mode64 & ~wr_phase) ?
      (a2p_free >= 4'h2) : a2p_ready;

   // Live flags for both directions
   assign status_now = {dir_flags(a2p_count), dir_flags(p2a_count)};

   // Flag copy for the PCI-side master status register
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pci_fifo_status <= {`ST_WIDTH{1'b0}};
      end else begin
         pci_fifo_status <= status_now;
      end
   end

   // Read data and bus drive, one cycle after the read is taken
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         addon_data_out <= 32'h00000000;
         addon_data_oe <= 1'b0;
      end else begin
         addon_data_oe <= reg_rd | ~fifo_read_strobe_n;
         if (fifo_rd_req) begin
            // FIFO read, empty FIFO returns zero
            addon_data_out <= p2a_valid ? convert(p2a_head, pci_endian_mode) : 32'h00000000;
         end else if (reg_rd & hit_status) begin
            // General status, upper bits zero
            addon_data_out <= {{(32 - `ST_WIDTH){1'b0}}, status_now};
         end else if (reg_rd) begin
            // Other locations belong to other blocks
            addon_data_out <= 32'h00000000;
         end
      end
   end
endmodule // addon_fifo_port
`default_nettype wire

/* File: test/addon_fifo_port_sva.sv */
// Checker for the add-on FIFO port, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module addon_fifo_port_sva (
   input wire logic clk, // Add-on clock
   input wire logic reset, // Async reset
   input wire logic addon_select_n, addon_rd_n, addon_wr_n, // Bus strobes
   input wire logic [6:2] addon_addr, // DWORD address
   input wire logic fifo_read_strobe_n, // DMA read strobe
   input wire logic addon_data_oe, // Bus drive enable
   input wire logic fifo_data_available_pin, fifo_space_available_pin, // Flag pins
   input wire logic [1:0] pci_endian_mode, // Conversion mode
   input wire logic pci_wr_ready, pci_rd_valid, // PCI side handshakes
   input wire logic [5:0] pci_fifo_status // PCI status copy
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Any register read drives the bus next cycle
   reg_read_oe_a: assert property (!addon_select_n && !addon_rd_n |=> addon_data_oe)
      else $error("no drive after register read");
   strobe_read_oe_a: assert property (!fifo_read_strobe_n |=> addon_data_oe)
      else $error("no drive after strobe read");
   oe_cause_a: assert property (addon_data_oe |-> $past(!fifo_read_strobe_n || !addon_select_n && !addon_rd_n))
      else $error("bus driven without a read");
   // Pins and PCI handshakes agree with status copy one cycle later
   avail_status_a: assert property (fifo_data_available_pin && pci_endian_mode == 2'h0 |=> !pci_fifo_status[2])
      else $error("empty bit set while data shown");
   full_status_a: assert property (!fifo_space_available_pin && pci_endian_mode == 2'h0 |=> pci_fifo_status[3])
      else $error("full bit clear while no space shown");
   rd_status_a: assert property (pci_rd_valid |=> !pci_fifo_status[5])
      else $error("empty bit set while words held");
   wr_status_a: assert property (!pci_wr_ready |=> pci_fifo_status[0])
      else $error("full bit clear while refusing");
   // A port write reaches the PCI side next cycle
   push_valid_a: assert property (!addon_select_n && !addon_wr_n && addon_addr == 5'h08 && fifo_space_available_pin
      && pci_endian_mode == 2'h0 |=> pci_rd_valid)
      else $error("written word not offered to PCI");
endmodule // addon_fifo_port_sva
bind addon_fifo_port addon_fifo_port_sva u_sva (.clk, .reset, .addon_select_n, .addon_rd_n, .addon_wr_n,
   .addon_addr, .fifo_read_strobe_n, .addon_data_oe, .fifo_data_available_pin, .fifo_space_available_pin,
   .pci_endian_mode, .pci_wr_ready, .pci_rd_valid, .pci_fifo_status);
`default_nettype wire

/* File: test/dma_agent.sv */
// Add-on DMA agent paced by the FIFO flag pins
`timescale 1ns/100ps
`default_nettype none
module dma_agent (
   input wire logic clk, reset, rd_en, wr_en, avail, space, // Enables and flag pins
   input wire logic [31:0] dout, // Port read data
   output logic rd_n, wr_n, // FIFO strobes, active low
   output logic [31:0] wd, last, // Word written, last word read
   output logic [7:0] n_rd // Words read
);
   logic took; // Read answer due now
   // Strobes on alternate cycles so a flag that drops after a pop is seen
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         {rd_n, wr_n, took, wd, last, n_rd} <= {3'h6, 72'h0};
      end else begin
         rd_n <= !(rd_en && avail && rd_n);
         wr_n <= !(wr_en && space && wr_n);
         took <= !rd_n;
         if (took) last <= dout;
         if (!rd_n) n_rd <= n_rd + 8'h1;
         if (!wr_n) wd <= wd + 32'h1;
      end
   end
endmodule // dma_agent
`default_nettype wire

/* File: test/addon_fifo_port_test.sv */
// Testbench for the add-on FIFO port
`timescale 1ns/100ps
`default_nettype none
module addon_fifo_port_test;
   logic clk, reset, sel_n, rd_n, wr_n, pv, prr, rd_en, wr_en; // Bench drives
   logic [4:0] ad; // Register address
   logic [31:0] bd, pd, din, dout, prd, dd, last; // Data paths
   logic [1:0] md; // Endian mode
   logic oe, av, sp, pwr, pvl, frn, fwn; // Outputs and strobes
   logic [5:0] st; // PCI status copy
   logic [7:0] nrd; // Words taken by DMA
   int num_errors = 0, tests_run = 0, i;
   assign din = fwn ? bd : dd; // DMA word while it writes
   addon_fifo_port u_dut (.clk, .reset, .addon_select_n(sel_n), .addon_rd_n(rd_n), .addon_wr_n(wr_n),
      .addon_addr(ad), .addon_data_in(din), .addon_data_out(dout), .addon_data_oe(oe), .fifo_read_strobe_n(frn),
      .fifo_write_strobe_n(fwn), .fifo_data_available_pin(av), .fifo_space_available_pin(sp), .pci_endian_mode(md),
      .pci_wr_valid(pv), .pci_wr_data(pd), .pci_wr_ready(pwr), .pci_rd_valid(pvl), .pci_rd_data(prd),
      .pci_rd_ready(prr), .pci_fifo_status(st));
   dma_agent u_dma (.clk, .reset, .rd_en, .wr_en, .avail(av), .space(sp), .dout, .rd_n(frn), .wr_n(fwn),
      .wd(dd), .last, .n_rd(nrd));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task chk(input [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task close_out;
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One register cycle, answer sampled after the taking edge
   task acc(input [4:0] a, input w, input [31:0] d);
      @(posedge clk) {sel_n, rd_n, wr_n, ad, bd} <= {1'h0, w, !w, a, d};
      @(posedge clk) {sel_n, rd_n, wr_n} <= 3'h7;
      #1;
   endtask
   task rdc(input [4:0] a, input [31:0] e);
      acc(a, 1'h0, 32'h0);
      chk(dout, e);
   endtask
   task pw(input [31:0] d);
      @(posedge clk) {pv, pd} <= {1'h1, d};
      @(posedge clk) pv <= 0;
      #1;
   endtask
   task pr(input [31:0] e);
      @(posedge clk) #1 chk(pvl, 1);
      chk(prd, e);
      @(posedge clk) prr <= 1;
      @(posedge clk) prr <= 0;
      #1;
   endtask
   task t_reset;
      #1 chk(av, 0);
      chk(sp, 1);
      rdc(5'h0f, 32'h36);
      rdc(5'h00, 32'h0);
   endtask
   task t_fill;
      for (i = 0; i < 9; i++) acc(5'h08, 1'h1, 32'h100 + i);
      chk(sp, 0);
      rdc(5'h0f, 32'h0e);
      rdc(5'h08, 32'h0);
      for (i = 0; i < 8; i++) pr(32'h100 + i);
      chk(pvl, 0);
      chk(sp, 1);
   endtask
   task t_p2a;
      for (i = 0; i < 5; i++) pw(32'h200 + i);
      chk(av, 1);
      rdc(5'h0f, 32'h30);
      for (i = 0; i < 5; i++) rdc(5'h08, 32'h200 + i);
      chk(av, 0);
      for (i = 0; i < 9; i++) pw(32'h300 + i);
      chk(pwr, 0);
      rdc(5'h0f, 32'h31);
      for (i = 0; i < 8; i++) rdc(5'h08, 32'h300 + i);
      chk(av, 0);
   endtask
   task t_modes;
      @(posedge clk) md <= 2'h1;
      pw(32'haabbccdd);
      rdc(5'h08, 32'hbbaaddcc);
      @(posedge clk) md <= 2'h2;
      pw(32'haabbccdd);
      rdc(5'h08, 32'hddccbbaa);
      @(posedge clk) md <= 2'h3;
      pw(32'h11223344);
      chk(av, 0);
      pw(32'h55667788);
      chk(av, 1);
      rdc(5'h08, 32'h44332211);
      rdc(5'h08, 32'h88776655);
      @(posedge clk) md <= 2'h0;
   endtask
   task t_dma;
      @(posedge clk) rd_en <= 1;
      for (i = 0; i < 6; i++) pw(32'h50 + i);
      for (i = 0; i < 50 && nrd != 6; i++) @(posedge clk) #1;
      @(posedge clk) rd_en <= 0;
      #1 chk(nrd, 6);
      if (nrd != 6) close_out;
      chk(last, 32'h55);
      @(posedge clk) wr_en <= 1;
      for (i = 0; i < 60 && sp; i++) @(posedge clk) #1;
      @(posedge clk) wr_en <= 0;
      #1 chk(sp, 0);
      if (sp) close_out;
      chk(dd, 8);
      for (i = 0; i < 8; i++) pr(i);
   endtask
   initial begin
      {reset, sel_n, rd_n, wr_n, ad, bd, pd, pv, prr, md, rd_en, wr_en} = {4'hf, 75'h0};
      repeat (20) @(posedge clk);
      reset <= 0;
      t_reset;
      t_fill;
      t_p2a;
      t_modes;
      t_dma;
      close_out;
   end
endmodule // addon_fifo_port_test
`default_nettype wire
